// >>> logic/asa_pkg.sv
// Constants shared by the serial adapter design.
// Assumes one system clock; all pins arrive from outside its domain.
package asa_pkg;
   // Control register fields
   localparam int CTL_DIV_LSB = 0;
   localparam int CTL_WLEN = 2;
   localparam int CTL_TXEN = 3;
   localparam int CTL_RTS = 4;
   localparam int CTL_TXIE = 5;
   localparam int CTL_RXEN = 6;
   localparam int CTL_RXIE = 7;
   localparam logic [7:0] CTL_RESET = 8'h00;
   // Synchroniser reset: pins at their idle levels, carrier present
   localparam logic [10:0] SYNC_IDLE = 11'h146;
   // Status register fields
   localparam int ST_RDRF = 0;
   localparam int ST_TDRE = 1;
   localparam int ST_DCD = 2;
   localparam int ST_CTS = 3;
   localparam int ST_FE = 4;
   localparam int ST_OVR = 5;
   localparam int ST_IRQ = 7;
   // Word lengths, divide ratios and divider counts
   localparam logic [3:0] BITS_8 = 4'h8;
   localparam logic [3:0] BITS_7 = 4'h7;
   localparam logic [1:0] DIV_1 = 2'h0;
   localparam logic [1:0] DIV_16 = 2'h1;
   localparam logic [1:0] DIV_64 = 2'h2;
   localparam logic [5:0] CNT_16 = 6'h0f;
   localparam logic [5:0] CNT_64 = 6'h3f;
   localparam logic [5:0] CNT_ZERO = 6'h00;
endpackage

// >>> logic/asa_buffer.sv
// Two-entry valid/ready buffer carrying received bytes to the bus side.
// Assumes a single clock and synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module asa_buffer
#(
   parameter int WIDTH = 9
)
(
   input wire logic clk,
   input wire logic rst,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   logic [WIDTH-1:0] mem [0:1];
   logic wp, rp;
   logic [1:0] cnt;
   logic next_wp, next_rp;
   logic [1:0] next_cnt;
   logic push, pop;

   assign in_ready = (cnt != 2'd2);
   assign out_valid = (cnt != 2'd0);
   assign out_data = mem[rp];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   always_comb
   begin
      next_wp = push ? ~wp : wp;
      next_rp = pop ? ~rp : rp;
      next_cnt = cnt + {1'b0, push} - {1'b0, pop};
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         wp <= 1'b0;
         rp <= 1'b0;
         cnt <= 2'd0;
      end
      else
      begin
         wp <= next_wp;
         rp <= next_rp;
         cnt <= next_cnt;
      end
      if (push)
         mem[wp] <= in_data;
   end
endmodule
`default_nettype wire

// >>> logic/asa_top.sv
// Serial adapter: byte bus registers, transmitter and receiver.
// Assumes pins and bit clocks are asynchronous to MCLK and much slower.
// Operation
// - Respond only when selects match pattern
// - Read drives bus, write stores byte
// - Pair select picks data or control
// - Direction picks read-only or write-only member
// - Enable strobe gates buffers, times transfers
// - Eight-bit bidirectional data bus
// - Interrupt low while enabled cause present
// - Transmit bits launched on falling edge
// - Receive sampled on rising edge
// - Clear-to-send low enables transmitter
// - Carrier loss halts reception
// - Request-to-send set by control write
// - Control selects length, divide, enables
// - Frame transmit bytes, deframe and check receive
`timescale 1ns/1ps
`default_nettype none
module asa_top
(
   // Clock and reset
   input wire logic MCLK,
   input wire logic RST,
   // Processor bus
   input wire logic SELECT_HI_A,
   input wire logic SELECT_HI_B,
   input wire logic SELECT_LO_N,
   input wire logic REG_PAIR_SELECT,
   input wire logic READ_NOT_WRITE,
   input wire logic BUS_ENABLE,
   input wire logic [7:0] HOST_DATA_BUS_IN,
   output logic [7:0] HOST_DATA_BUS_OUT,
   output logic HOST_DATA_BUS_OE,
   output logic IRQ_N,
   // Serial link
   input wire logic TX_BIT_CLOCK,
   input wire logic RX_BIT_CLOCK,
   input wire logic SERIAL_IN,
   output logic SERIAL_OUT,
   input wire logic CLEAR_TO_SEND_N,
   input wire logic CARRIER_DETECT_N,
   output logic REQUEST_TO_SEND_N
);
   // ==========================================================
   // Input synchronisers
   // ==========================================================
   localparam int NS = 11;
   logic [NS-1:0] raw, s1, s2;
   assign raw = {SELECT_HI_A, SELECT_HI_B, SELECT_LO_N, REG_PAIR_SELECT, READ_NOT_WRITE,
                 BUS_ENABLE, TX_BIT_CLOCK, RX_BIT_CLOCK, SERIAL_IN, CLEAR_TO_SEND_N,
                 CARRIER_DETECT_N};
   always_ff @(posedge MCLK)
   begin
      if (RST)
      begin
         s1 <= asa_pkg::SYNC_IDLE;
         s2 <= asa_pkg::SYNC_IDLE;
      end
      else
      begin
         s1 <= raw;
         s2 <= s1;
      end
   end
   logic sa, sb, sn, rsel, rnw, en, txc, rxc, rxd, cts_n, dcd_n;
   assign {sa, sb, sn, rsel, rnw, en, txc, rxc, rxd, cts_n, dcd_n} = s2;
   logic [7:0] din_s1, din;
   always_ff @(posedge MCLK)
   begin
      din_s1 <= HOST_DATA_BUS_IN;
      din <= din_s1;
   end
   logic en_d, txc_d, rxc_d;
   always_ff @(posedge MCLK)
   begin
      if (RST)
      begin
         en_d <= 1'b0;
         txc_d <= 1'b0;
         rxc_d <= 1'b0;
      end
      else
      begin
         en_d <= en;
         txc_d <= txc;
         rxc_d <= rxc;
      end
   end
   logic sel;
   assign sel = sa && sb && !sn;
   // falling enable edge ends a transfer
   logic xfer_end;
   assign xfer_end = sel && en_d && !en;
   logic tx_fall, rx_rise;
   assign tx_fall = txc_d && !txc;
   assign rx_rise = !rxc_d && rxc;

   // ==========================================================
   // Registers
   // ==========================================================
   logic [7:0] ctl, tdr, next_ctl, next_tdr;
   logic tdre, next_tdre, fe, ovr, next_fe, next_ovr, dcd_lost, next_dcd_lost;
   logic wr_ctl, wr_tdr, rd_rdr, rd_st, tx_load;
   logic [8:0] rb_data;
   logic rb_valid;
   assign wr_ctl = xfer_end && !rnw && !rsel;
   assign wr_tdr = xfer_end && !rnw && rsel;
   assign rd_rdr = xfer_end && rnw && rsel;
   assign rd_st = xfer_end && rnw && !rsel;
   logic irq_now;
   assign irq_now = (ctl[asa_pkg::CTL_RXIE] && (rb_valid || dcd_lost))
                  || (ctl[asa_pkg::CTL_TXIE] && tdre && !cts_n);
   logic [7:0] status;
   always_comb
   begin
      status = 8'h00;
      status[asa_pkg::ST_RDRF] = rb_valid;
      status[asa_pkg::ST_TDRE] = tdre;
      status[asa_pkg::ST_DCD] = dcd_lost;
      status[asa_pkg::ST_CTS] = cts_n;
      status[asa_pkg::ST_FE] = fe;
      status[asa_pkg::ST_OVR] = ovr;
      status[asa_pkg::ST_IRQ] = irq_now;
   end
   logic rx_done, rx_fe, rb_in_ready;
   always_comb
   begin
      next_ctl = wr_ctl ? din : ctl;
      next_tdr = wr_tdr ? din : tdr;
      next_tdre = wr_tdr ? 1'b0 : (tx_load ? 1'b1 : tdre);
      // Hardware sets win over read clears
      next_fe = rx_done ? rx_fe : (rd_rdr ? 1'b0 : fe);
      next_ovr = (rx_done && !rb_in_ready) ? 1'b1 : (rd_rdr ? 1'b0 : ovr);
      next_dcd_lost = dcd_n ? 1'b1 : ((rd_st || rd_rdr) ? 1'b0 : dcd_lost);
   end
   always_ff @(posedge MCLK)
   begin
      if (RST)
      begin
         ctl <= asa_pkg::CTL_RESET;
         tdr <= 8'h00;
         tdre <= 1'b1;
         fe <= 1'b0;
         ovr <= 1'b0;
         dcd_lost <= 1'b0;
      end
      else
      begin
         ctl <= next_ctl;
         tdr <= next_tdr;
         tdre <= next_tdre;
         fe <= next_fe;
         ovr <= next_ovr;
         dcd_lost <= next_dcd_lost;
      end
   end

   // ==========================================================
   // Bus outputs
   // ==========================================================
   logic [7:0] next_dout;
   logic next_oe;
   always_comb
   begin
      // drive only during selected read enable
      next_oe = sel && rnw && en;
      next_dout = rsel ? rb_data[7:0] : status;
   end
   always_ff @(posedge MCLK)
   begin
      if (RST)
      begin
         HOST_DATA_BUS_OUT <= 8'h00;
         HOST_DATA_BUS_OE <= 1'b0;
         IRQ_N <= 1'b1;
         REQUEST_TO_SEND_N <= 1'b1;
      end
      else
      begin
         HOST_DATA_BUS_OUT <= next_dout;
         HOST_DATA_BUS_OE <= next_oe;
         IRQ_N <= !irq_now;
         REQUEST_TO_SEND_N <= !ctl[asa_pkg::CTL_RTS];
      end
   end

   // ==========================================================
   // Bit-rate enables from the divided link clocks
   // ==========================================================
   logic [5:0] tdiv, rdiv, next_tdiv, next_rdiv, dmax;
   assign dmax = (ctl[1:0] == asa_pkg::DIV_16) ? asa_pkg::CNT_16 :
                 (ctl[1:0] == asa_pkg::DIV_64) ? asa_pkg::CNT_64 : asa_pkg::CNT_ZERO;
   logic tx_tick, rx_tick;
   assign tx_tick = tx_fall && (tdiv == asa_pkg::CNT_ZERO);
   assign rx_tick = rx_rise && (rdiv == asa_pkg::CNT_ZERO);

   // ==========================================================
   // Transmitter
   // ==========================================================
   typedef enum logic [1:0] {TX_IDLE = 2'b01, TX_SHIFT = 2'b10} asa_tx_type;
   asa_tx_type tst, next_tst;
   logic [9:0] tsh, next_tsh;
   logic [3:0] tcnt, next_tcnt, nbits;
   logic next_sout;
   assign nbits = ctl[asa_pkg::CTL_WLEN] ? asa_pkg::BITS_7 : asa_pkg::BITS_8;
   assign tx_load = (tst == TX_IDLE) && tx_tick && !tdre && !cts_n && ctl[asa_pkg::CTL_TXEN];
   always_comb
   begin
      next_tst = tst;
      next_tsh = tsh;
      next_tcnt = tcnt;
      next_sout = SERIAL_OUT;
      next_tdiv = tx_fall ? ((tdiv == asa_pkg::CNT_ZERO) ? dmax : tdiv - 6'd1) : tdiv;
      unique case (tst)
         TX_IDLE:
         begin
            next_sout = 1'b1;
            if (tx_load)
            begin
               // start low, data LSB first, stop high
               next_sout = 1'b0;
               next_tsh = {2'b11, tdr};
               next_tcnt = nbits;
               next_tst = TX_SHIFT;
            end
         end
         TX_SHIFT:
         begin
            if (tx_tick)
            begin
               next_sout = tsh[0];
               next_tsh = {1'b1, tsh[9:1]};
               if (tcnt == 4'd0)
               begin
                  next_sout = 1'b1;
                  next_tst = TX_IDLE;
               end
               else
                  next_tcnt = tcnt - 4'd1;
            end
         end
      endcase
   end
   always_ff @(posedge MCLK)
   begin
      if (RST)
      begin
         tst <= TX_IDLE;
         tsh <= 10'h3ff;
         tcnt <= 4'd0;
         tdiv <= 6'd0;
         SERIAL_OUT <= 1'b1;
      end
      else
      begin
         tst <= next_tst;
         tsh <= next_tsh;
         tcnt <= next_tcnt;
         tdiv <= next_tdiv;
         SERIAL_OUT <= next_sout;
      end
   end

   // ==========================================================
   // Receiver
   // ==========================================================
   typedef enum logic [1:0] {RX_IDLE = 2'b01, RX_DATA = 2'b10} asa_rx_type;
   asa_rx_type rst_q, next_rst_q;
   logic [7:0] rsh, next_rsh;
   logic [3:0] rcnt, next_rcnt;
   logic rx_run;
   assign rx_run = !dcd_n && ctl[asa_pkg::CTL_RXEN];
   always_comb
   begin
      next_rst_q = rst_q;
      next_rsh = rsh;
      next_rcnt = rcnt;
      rx_done = 1'b0;
      rx_fe = 1'b0;
      next_rdiv = rx_rise ? ((rdiv == asa_pkg::CNT_ZERO) ? dmax : rdiv - 6'd1) : rdiv;
      if (!rx_run)
      begin
         next_rst_q = RX_IDLE;
         next_rdiv = dmax >> 1;
      end
      else
         unique case (rst_q)
            RX_IDLE:
            begin
               // Half-bit count loaded while idle; start detection reloads the full dmax count
               next_rdiv = dmax >> 1;
               if (rx_rise && !rxd)
               begin
                  next_rst_q = RX_DATA;
                  next_rcnt = nbits;
                  next_rsh = 8'h00;
                  next_rdiv = dmax;
               end
            end
            RX_DATA:
            begin
               if (rx_tick)
               begin
                  if (rcnt == 4'd0)
                  begin
                     rx_done = 1'b1;
                     rx_fe = !rxd;
                     next_rst_q = RX_IDLE;
                  end
                  else
                  begin
                     next_rsh = {rxd, rsh[7:1]};
                     next_rcnt = rcnt - 4'd1;
                  end
               end
            end
         endcase
   end
   always_ff @(posedge MCLK)
   begin
      if (RST)
      begin
         rst_q <= RX_IDLE;
         rsh <= 8'h00;
         rcnt <= 4'd0;
         rdiv <= 6'd0;
      end
      else
      begin
         rst_q <= next_rst_q;
         rsh <= next_rsh;
         rcnt <= next_rcnt;
         rdiv <= next_rdiv;
      end
   end
   logic [7:0] rx_word;
   assign rx_word = ctl[asa_pkg::CTL_WLEN] ? {1'b0, rsh[7:1]} : rsh;

   asa_buffer #(.WIDTH(9)) u_rxbuf
   (
      .clk(MCLK),
      .rst(RST),
      .in_valid(rx_done),
      .in_ready(rb_in_ready),
      .in_data({rx_fe, rx_word}),
      .out_valid(rb_valid),
      .out_ready(rd_rdr),
      .out_data(rb_data)
   );

   // ==========================================================
   // Checks
   // ==========================================================
   a_select_gate: assert property (@(posedge MCLK) disable iff (RST)
      !(sa && sb && !sn) |=> !HOST_DATA_BUS_OE) else $error("bus driven while unselected");
   a_write_no_drive: assert property (@(posedge MCLK) disable iff (RST)
      !rnw |=> !HOST_DATA_BUS_OE) else $error("bus driven during write");
   a_ctl_write: assert property (@(posedge MCLK) disable iff (RST)
      wr_ctl |=> ctl == $past(din)) else $error("control write lost");
   a_irq_level: assert property (@(posedge MCLK) disable iff (RST)
      irq_now |=> !IRQ_N) else $error("interrupt not asserted");
   a_cts_block: assert property (@(posedge MCLK) disable iff (RST)
      cts_n |-> !tx_load) else $error("transmit began without clear to send");
   a_dcd_halt: assert property (@(posedge MCLK) disable iff (RST)
      dcd_n |=> rst_q == RX_IDLE) else $error("receiver ran without carrier");
   a_tx_edge: assert property (@(posedge MCLK) disable iff (RST)
      $changed(SERIAL_OUT) |-> $past(tx_fall)) else $error("transmit bit off falling edge");
   a_rts_follow: assert property (@(posedge MCLK) disable iff (RST)
      wr_ctl |=> ##1 REQUEST_TO_SEND_N == !ctl[asa_pkg::CTL_RTS]) else $error("rts mismatch");
   a_start_low: assert property (@(posedge MCLK) disable iff (RST)
      tx_load |=> !SERIAL_OUT) else $error("start bit not low");
   c_tx_frame: cover property (@(posedge MCLK) disable iff (RST) tx_load);
   c_rx_frame: cover property (@(posedge MCLK) disable iff (RST) rx_done && !rx_fe);
   c_overrun: cover property (@(posedge MCLK) disable iff (RST) rx_done && !rb_in_ready);
endmodule
`default_nettype wire

// >>> testbench/asa_modem.sv
// Far-side serial device: makes both bit clocks, frames and captures characters.
// Assumes a 400 ns bit clock and the adapter dividing by the ratio in div.
`timescale 1ns/1ps
`default_nettype none
module asa_modem
(
   // Serial link
   output logic tx_clk,
   output logic rx_clk,
   output logic rx_line,
   input wire logic tx_line
);
   int div = 1;
   initial
   begin
      tx_clk = 1'b0;
      rx_clk = 1'b0;
      rx_line = 1'b1;
   end
   // start, data LSB first, stop, set up before the rising edge
   task automatic send(input logic [7:0] d, input logic stop);
      logic [9:0] f;
      f = {stop, d, 1'b0};
      for (int i = 0; i < 12; i++)
      begin
         rx_line = (i < 10) ? f[i] : 1'b1;
         repeat (div)
         begin
            #200 rx_clk = 1'b1;
            #200 rx_clk = 1'b0;
         end
      end
   endtask
   // sample on rising edges, adapter launches on falling ones
   task automatic recv(input int lim, output logic [7:0] d, output logic stop,
      output logic ok);
      int n;
      n = 0;
      ok = 1'b0;
      d = 8'h00;
      stop = 1'b0;
      while (!ok && n < lim)
      begin
         #200 tx_clk = 1'b1;
         ok = (tx_line === 1'b0);
         #200 tx_clk = 1'b0;
         n++;
      end
      for (int i = 0; ok && i < 9; i++)
      begin
         #200 tx_clk = 1'b1;
         if (i < 8)
            d[i] = tx_line;
         else
            stop = tx_line;
         #200 tx_clk = 1'b0;
      end
   endtask
endmodule
`default_nettype wire

// >>> testbench/asa_top_test.sv
// Self-checking bench for the serial adapter: bus tasks and frame scenarios.
// Assumes the far-side model in asa_modem and a 20 MHz MCLK.
`timescale 1ns/1ps
`default_nettype none
module asa_top_test;
   logic mclk, rst, rsel, rnw, en, cts_n, dcd_n, oe, irq_n, sout, rts_n;
   logic txc, rxc, sin, st, ok;
   logic [2:0] sel;
   logic [7:0] din, dout, r, b;
   logic [2:0] bad [3] = '{3'b010, 3'b100, 3'b111};
   int num_errors = 0;
   int n_tests = 0;

   asa_top u_asa_top (.MCLK(mclk), .RST(rst), .SELECT_HI_A(sel[2]),
      .SELECT_HI_B(sel[1]), .SELECT_LO_N(sel[0]), .REG_PAIR_SELECT(rsel),
      .READ_NOT_WRITE(rnw), .BUS_ENABLE(en), .HOST_DATA_BUS_IN(din),
      .HOST_DATA_BUS_OUT(dout), .HOST_DATA_BUS_OE(oe), .IRQ_N(irq_n),
      .TX_BIT_CLOCK(txc), .RX_BIT_CLOCK(rxc), .SERIAL_IN(sin), .SERIAL_OUT(sout),
      .CLEAR_TO_SEND_N(cts_n), .CARRIER_DETECT_N(dcd_n), .REQUEST_TO_SEND_N(rts_n));
   asa_modem u_asa_modem (.tx_clk(txc), .rx_clk(rxc), .rx_line(sin), .tx_line(sout));

   // ==========================================
   // Checks and bus tasks
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         num_errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic summarize();
      $display("Checks %0d, errors %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task automatic access(input logic [2:0] s, input logic rs, input logic rw,
      input logic [7:0] wd, output logic [7:0] rd);
      @(posedge mclk);
      sel <= s;
      rsel <= rs;
      rnw <= rw;
      din <= wd;
      en <= 1'b1;
      repeat (4) @(posedge mclk);
      @(negedge mclk);
      rd = dout;
      chk({7'h00, oe}, {7'h00, rw && s == 3'b110});
      @(posedge mclk);
      en <= 1'b0;
      repeat (4) @(posedge mclk);
      sel <= 3'b001;
      repeat (2) @(posedge mclk);
   endtask
   task automatic wr(input logic rs, input logic [7:0] d);
      logic [7:0] t;
      access(3'b110, rs, 1'b0, d, t);
   endtask
   task automatic rd(input logic rs, input logic [7:0] exp, input logic [7:0] m);
      logic [7:0] t;
      access(3'b110, rs, 1'b1, 8'h00, t);
      chk(t & m, exp);
   endtask

   initial
   begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end
   initial
   begin
      repeat (20000) @(posedge mclk);
      num_errors++;
      summarize();
   end

   // ==========================================
   // Scenarios
   initial
   begin
      rst = 1'b1;
      sel = 3'b001;
      rsel = 1'b0;
      rnw = 1'b1;
      en = 1'b0;
      din = 8'h00;
      cts_n = 1'b0;
      dcd_n = 1'b0;
      repeat (12) @(posedge mclk);
      rst <= 1'b0;
      repeat (3) @(posedge mclk);
      chk({irq_n, sout, rts_n, oe, 4'h0}, 8'he0);
      foreach (bad[i])
      begin
         access(bad[i], 1'b0, 1'b0, 8'h10, r);
         chk({7'h00, rts_n}, 8'h01);
      end
      wr(1'b0, 8'h18);
      chk({7'h00, rts_n}, 8'h00);
      rd(1'b0, 8'h02, 8'h0a);
      cts_n <= 1'b1;
      wr(1'b1, 8'ha5);
      rd(1'b0, 8'h08, 8'h0a);
      u_asa_modem.recv(15, b, st, ok);
      chk({7'h00, ok}, 8'h00);
      cts_n <= 1'b0;
      repeat (4) @(posedge mclk);
      u_asa_modem.recv(15, b, st, ok);
      chk(b, 8'ha5);
      chk({7'h00, st}, 8'h01);
      wr(1'b0, 8'h0c);
      wr(1'b1, 8'h41);
      u_asa_modem.recv(15, b, st, ok);
      chk(b, 8'hc1);
      wr(1'b0, 8'hc8);
      u_asa_modem.send(8'h5a, 1'b1);
      repeat (4) @(posedge mclk);
      chk({7'h00, irq_n}, 8'h00);
      rd(1'b0, 8'h81, 8'h81);
      rd(1'b1, 8'h5a, 8'hff);
      repeat (2) @(posedge mclk);
      chk({7'h00, irq_n}, 8'h01);
      u_asa_modem.send(8'h11, 1'b1);
      u_asa_modem.send(8'h22, 1'b1);
      u_asa_modem.send(8'h33, 1'b1);
      rd(1'b0, 8'h21, 8'h21);
      rd(1'b1, 8'h11, 8'hff);
      rd(1'b1, 8'h22, 8'hff);
      rd(1'b0, 8'h00, 8'h21);
      u_asa_modem.send(8'h77, 1'b0);
      rd(1'b0, 8'h10, 8'h10);
      access(3'b110, 1'b1, 1'b1, 8'h00, r);
      rd(1'b0, 8'h00, 8'h11);
      dcd_n <= 1'b1;
      repeat (6) @(posedge mclk);
      chk({7'h00, irq_n}, 8'h00);
      u_asa_modem.send(8'h66, 1'b1);
      rd(1'b0, 8'h04, 8'h05);
      dcd_n <= 1'b0;
      repeat (4) @(posedge mclk);
      access(3'b110, 1'b0, 1'b1, 8'h00, r);
      rd(1'b0, 8'h00, 8'h05);
      chk({7'h00, irq_n}, 8'h01);
      u_asa_modem.send(8'h99, 1'b1);
      rd(1'b1, 8'h99, 8'hff);
      wr(1'b0, 8'hc9);
      u_asa_modem.div = 16;
      u_asa_modem.send(8'h3c, 1'b1);
      rd(1'b1, 8'h3c, 8'hff);
      summarize();
   end
endmodule
`default_nettype wire
